//--- src/spt_regs.vh
/*
 Register map, access-rights field positions, access kinds, fault codes
 and reset values of the segment translate and protect block.
 Assumes inclusion by bare name from the block's single design file.
*/
// Behaviour
// - Setting protection flag enables protected addressing.
// - Drive 24-bit byte address plus high-byte enable.
// - Unmapped use faults, leaving state restartable.
// - Selector indexes descriptor table, not memory.
// - Physical address is base plus offset.
// - Segment load fetches its descriptor automatically.
// - Descriptors are eight bytes, four words.
// - Descriptor reads and update run locked.
// - Violations suppress memory cycle, raise exception.
// - Clear present bit gives not-present fault.
// - Bits six to five hold privilege level.
// - Bit four selects code/data versus system.
// - Bit three set means code segment.
// - Expand direction sets limit comparison sense.
// - Read-only data segments reject writes.
// - Code never written; execute-only never read.
// - Conforming code needs current level at least descriptor's.
// - Accessed bit written back on descriptor access.
// - Limit gives last valid byte, up to 64K.
// - Four cached descriptors, used for all references.
`ifndef SPT_REGS_VH
`define SPT_REGS_VH

// ==========================================
// Register offsets (byte addresses)
`define SPT_OFF_CTRL 8'h00
`define SPT_OFF_TBASE 8'h04
`define SPT_OFF_SEL 8'h08
`define SPT_OFF_ACC 8'h0C
`define SPT_OFF_STAT 8'h10
`define SPT_OFF_ADDR 8'h14
`define SPT_OFF_DATA 8'h18
`define SPT_OFF_CACHE 8'h1C

// ==========================================
// Access-rights byte fields
`define SPT_AR_P 7
`define SPT_AR_DPL_HI 6
`define SPT_AR_DPL_LO 5
`define SPT_AR_S 4
`define SPT_AR_E 3
`define SPT_AR_DIR 2
`define SPT_AR_WR 1
`define SPT_AR_A 0
`define SPT_AR_REAL 8'h93

// ==========================================
// Access kinds and fault codes
`define SPT_KIND_READ 2'h0
`define SPT_KIND_WRITE 2'h1
`define SPT_KIND_EXEC 2'h2
`define SPT_FLT_NONE 4'h0
`define SPT_FLT_NOTPRES 4'h1
`define SPT_FLT_CLASS 4'h2
`define SPT_FLT_PRIV 4'h3
`define SPT_FLT_LIMIT 4'h4
`define SPT_FLT_RIGHTS 4'h5
`define SPT_FLT_NOCACHE 4'h6
`define SPT_FLT_ALIGN 4'h7

// ==========================================
// Reset values and sizes
`define SPT_RST_TBASE 24'h000000
`define SPT_RST_LIMIT 16'hFFFF
`define SPT_DESC_WORDS 2'h3
`endif

//--- src/spt_translate.v
/*
 Segment translate and protect block: descriptor cache for four segment
 registers, descriptor fetch over a locked local bus, access checking and
 data cycles, with an Avalon-MM slave for software control.
 Assumes the local bus memory runs on sys_clk and answers with memReady.
*/
`timescale 1ns/1ns
`include "spt_regs.vh"

module spt_translate (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] avAddress,
    input wire avRead,
    input wire avWrite,
    input wire [31:0] avWritedata,
    output reg [31:0] avReaddata,
    output reg avWaitrequest,
    output reg [23:0] memAddr,
    output reg high_byte_enable_n,
    output reg memRead,
    output reg memWrite,
    output reg memLock,
    output reg [15:0] memWdata,
    input wire [15:0] memRdata,
    input wire memReady,
    output reg exceptionRaise
);

    localparam ST_IDLE = 2'h0;
    localparam ST_FETCH = 2'h1;
    localparam ST_WBACK = 2'h2;
    localparam ST_DATA = 2'h3;

    // ==========================================
    // Helpers
    function [23:0] descAddr;
        input [23:0] base;
        input [15:0] sel;
        input [1:0] word;
        begin
            descAddr = base + {8'h00, sel[15:3], 3'h0} + {21'h0, word, 1'b0};
        end
    endfunction

    function [3:0] chkFault;
        input [7:0] ar;
        input [15:0] lim;
        input [15:0] off;
        input wide;
        input [1:0] kind;
        input [1:0] current_priv_level;
        reg [16:0] last;
        reg [1:0] descriptor_priv_level;
        begin
            last = {1'b0, off} + {16'h0000, wide};
            descriptor_priv_level = ar[`SPT_AR_DPL_HI:`SPT_AR_DPL_LO];
            chkFault = `SPT_FLT_NONE;
            if (!ar[`SPT_AR_P]) begin
                chkFault = `SPT_FLT_NOTPRES;
            end else if (!ar[`SPT_AR_S]) begin
                chkFault = `SPT_FLT_CLASS;
            end else if (ar[`SPT_AR_E]) begin
                if (kind == `SPT_KIND_WRITE) begin
                    chkFault = `SPT_FLT_RIGHTS;
                end else if (kind == `SPT_KIND_READ && !ar[`SPT_AR_WR]) begin
                    chkFault = `SPT_FLT_RIGHTS;
                end else if (kind == `SPT_KIND_EXEC && ar[`SPT_AR_DIR] && current_priv_level < descriptor_priv_level) begin
                    chkFault = `SPT_FLT_PRIV;
                end else if (kind == `SPT_KIND_EXEC && !ar[`SPT_AR_DIR] && current_priv_level != descriptor_priv_level) begin
                    chkFault = `SPT_FLT_PRIV;
                end else if (last > {1'b0, lim}) begin
                    chkFault = `SPT_FLT_LIMIT;
                end
            end else begin
                if (kind == `SPT_KIND_EXEC) begin
                    chkFault = `SPT_FLT_CLASS;
                end else if (kind == `SPT_KIND_WRITE && !ar[`SPT_AR_WR]) begin
                    chkFault = `SPT_FLT_RIGHTS;
                end else if (current_priv_level > descriptor_priv_level) begin
                    chkFault = `SPT_FLT_PRIV;
                end else if (!ar[`SPT_AR_DIR] && last > {1'b0, lim}) begin
                    chkFault = `SPT_FLT_LIMIT;
                end else if (ar[`SPT_AR_DIR] && (off <= lim || last[16])) begin
                    chkFault = `SPT_FLT_LIMIT;
                end
            end
        end
    endfunction

    // ==========================================
    // State
    reg [1:0] state_ff;
    reg protOn_ff;
    reg [1:0] cpl_ff;
    reg [23:0] tblBase_ff;
    reg [15:0] sel_ff;
    reg [1:0] seg_ff;
    reg [1:0] kind_ff;
    reg wide_ff;
    reg [15:0] off_ff;
    reg [15:0] dataW_ff;
    reg [15:0] dataR_ff;
    reg [23:0] phys_ff;
    reg fault_ff;
    reg [3:0] faultCode_ff;
    reg [1:0] wordCnt_ff;
    reg [15:0] dLim_ff;
    reg [15:0] dBaseLo_ff;
    reg [7:0] dBaseHi_ff;
    reg [7:0] dAr_ff;
    reg [23:0] cBase [0:3];
    reg [15:0] cLim [0:3];
    reg [7:0] cAr [0:3];
    reg [3:0] cValid_ff;
    integer i;

    wire req = avRead | avWrite;
    wire isOp = avWrite && (avAddress == `SPT_OFF_SEL || avAddress == `SPT_OFF_ACC);
    wire startOp = isOp && avWaitrequest && state_ff == ST_IDLE;
    wire simpleAns = req && !isOp && avWaitrequest && state_ff == ST_IDLE;
    wire commit = req && !avWaitrequest;
    wire [1:0] accSeg = avWritedata[17:16];
    wire [1:0] accKind = avWritedata[21:20];
    wire accWide = avWritedata[19];
    wire [15:0] accOff = avWritedata[15:0];
    wire [23:0] accPhys = cBase[accSeg] + {8'h00, accOff};
    wire [3:0] accFlt = cValid_ff[accSeg] ?
        chkFault(cAr[accSeg], cLim[accSeg], accOff, accWide, accKind, cpl_ff) :
        `SPT_FLT_NOCACHE;

    reg [31:0] rdVal;
    always @* begin
        case (avAddress)
            `SPT_OFF_CTRL: rdVal = {29'h0, cpl_ff, protOn_ff};
            `SPT_OFF_TBASE: rdVal = {8'h00, tblBase_ff};
            `SPT_OFF_SEL: rdVal = {14'h0, seg_ff, sel_ff};
            `SPT_OFF_ACC: rdVal = {10'h0, kind_ff, wide_ff, 1'b0, seg_ff, off_ff};
            `SPT_OFF_STAT: rdVal = {20'h0, cValid_ff, faultCode_ff, 3'h0, fault_ff};
            `SPT_OFF_ADDR: rdVal = {8'h00, phys_ff};
            `SPT_OFF_DATA: rdVal = {16'h0000, dataR_ff};
            `SPT_OFF_CACHE: rdVal = {cAr[seg_ff], cBase[seg_ff]};
            default: rdVal = 32'h00000000;
        endcase
    end

    // ==========================================
    // Bus slave, sequencer and cache
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            avReaddata <= 32'h00000000;
            avWaitrequest <= 1'b1;
            memAddr <= 24'h000000;
            high_byte_enable_n <= 1'b1;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            memLock <= 1'b0;
            memWdata <= 16'h0000;
            exceptionRaise <= 1'b0;
            protOn_ff <= 1'b0;
            cpl_ff <= 2'h0;
            tblBase_ff <= `SPT_RST_TBASE;
            sel_ff <= 16'h0000;
            seg_ff <= 2'h0;
            kind_ff <= 2'h0;
            wide_ff <= 1'b0;
            off_ff <= 16'h0000;
            dataW_ff <= 16'h0000;
            dataR_ff <= 16'h0000;
            phys_ff <= 24'h000000;
            fault_ff <= 1'b0;
            faultCode_ff <= `SPT_FLT_NONE;
            wordCnt_ff <= 2'h0;
            dLim_ff <= 16'h0000;
            dBaseLo_ff <= 16'h0000;
            dBaseHi_ff <= 8'h00;
            dAr_ff <= 8'h00;
            cValid_ff <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                cBase[i] <= 24'h000000;
                cLim[i] <= `SPT_RST_LIMIT;
                cAr[i] <= 8'h00;
            end
        end else begin
            exceptionRaise <= 1'b0;
            if (simpleAns) begin
                avReaddata <= rdVal;
                avWaitrequest <= 1'b0;
            end
            if (commit) begin
                avWaitrequest <= 1'b1;
                if (avWrite && avAddress == `SPT_OFF_CTRL) begin
                    // Only reset leaves protected addressing once it is on.
                    protOn_ff <= protOn_ff | avWritedata[0];
                    cpl_ff <= avWritedata[2:1];
                end
                if (avWrite && avAddress == `SPT_OFF_TBASE) begin
                    tblBase_ff <= avWritedata[23:0];
                end
                if (avWrite && avAddress == `SPT_OFF_DATA) begin
                    dataW_ff <= avWritedata[15:0];
                end
                if (avWrite && avAddress == `SPT_OFF_STAT && avWritedata[0]) begin
                    fault_ff <= 1'b0;
                end
            end
            case (state_ff)
                ST_IDLE: begin
                    if (startOp && avAddress == `SPT_OFF_SEL) begin
                        sel_ff <= avWritedata[15:0];
                        seg_ff <= accSeg;
                        if (protOn_ff) begin
                            wordCnt_ff <= 2'h0;
                            memAddr <= descAddr(tblBase_ff, avWritedata[15:0], 2'h0);
                            high_byte_enable_n <= 1'b0;
                            memRead <= 1'b1;
                            memLock <= 1'b1;
                            state_ff <= ST_FETCH;
                        end else begin
                            cBase[accSeg] <= {4'h0, avWritedata[15:0], 4'h0};
                            cLim[accSeg] <= `SPT_RST_LIMIT;
                            cAr[accSeg] <= `SPT_AR_REAL;
                            cValid_ff[accSeg] <= 1'b1;
                            avWaitrequest <= 1'b0;
                        end
                    end
                    if (startOp && avAddress == `SPT_OFF_ACC) begin
                        seg_ff <= accSeg;
                        kind_ff <= accKind;
                        wide_ff <= accWide;
                        off_ff <= accOff;
                        phys_ff <= accPhys;
                        if (protOn_ff && accFlt != `SPT_FLT_NONE) begin
                            // No bus cycle and no state change, so the access can be retried.
                            fault_ff <= 1'b1;
                            faultCode_ff <= accFlt;
                            exceptionRaise <= 1'b1;
                            avWaitrequest <= 1'b0;
                        end else if (accWide && accPhys[0]) begin
                            fault_ff <= 1'b1;
                            faultCode_ff <= `SPT_FLT_ALIGN;
                            exceptionRaise <= 1'b1;
                            avWaitrequest <= 1'b0;
                        end else begin
                            memAddr <= accPhys;
                            high_byte_enable_n <= !(accWide || accPhys[0]);
                            memRead <= accKind != `SPT_KIND_WRITE;
                            memWrite <= accKind == `SPT_KIND_WRITE;
                            memWdata <= (accPhys[0] && !accWide) ?
                                {dataW_ff[7:0], 8'h00} : dataW_ff;
                            state_ff <= ST_DATA;
                        end
                    end
                end
                ST_FETCH: begin
                    if (memReady) begin
                        case (wordCnt_ff)
                            2'h0: dLim_ff <= memRdata;
                            2'h1: dBaseLo_ff <= memRdata;
                            2'h2: {dAr_ff, dBaseHi_ff} <= memRdata;
                            default: dLim_ff <= dLim_ff;
                        endcase
                        if (wordCnt_ff == `SPT_DESC_WORDS) begin
                            memRead <= 1'b0;
                            if (!dAr_ff[`SPT_AR_P] || !dAr_ff[`SPT_AR_S]) begin
                                // Base and limit are ignored; the cache keeps its old copy.
                                memLock <= 1'b0;
                                high_byte_enable_n <= 1'b1;
                                fault_ff <= 1'b1;
                                faultCode_ff <= dAr_ff[`SPT_AR_P] ?
                                    `SPT_FLT_CLASS : `SPT_FLT_NOTPRES;
                                exceptionRaise <= 1'b1;
                                avWaitrequest <= 1'b0;
                                state_ff <= ST_IDLE;
                            end else begin
                                memAddr <= descAddr(tblBase_ff, sel_ff, 2'h2);
                                memWdata <= {dAr_ff | 8'h01, dBaseHi_ff};
                                memWrite <= 1'b1;
                                state_ff <= ST_WBACK;
                            end
                        end else begin
                            wordCnt_ff <= wordCnt_ff + 2'h1;
                            memAddr <= descAddr(tblBase_ff, sel_ff, wordCnt_ff + 2'h1);
                        end
                    end
                end
                ST_WBACK: begin
                    if (memReady) begin
                        memWrite <= 1'b0;
                        memLock <= 1'b0;
                        high_byte_enable_n <= 1'b1;
                        cBase[seg_ff] <= {dBaseHi_ff, dBaseLo_ff};
                        cLim[seg_ff] <= dLim_ff;
                        cAr[seg_ff] <= dAr_ff | 8'h01;
                        cValid_ff[seg_ff] <= 1'b1;
                        avWaitrequest <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (memReady) begin
                        memRead <= 1'b0;
                        memWrite <= 1'b0;
                        high_byte_enable_n <= 1'b1;
                        dataR_ff <= (phys_ff[0] && !wide_ff) ?
                            {8'h00, memRdata[15:8]} : memRdata;
                        avWaitrequest <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

endmodule

//--- test/spt_translate_checker.sv
/* Port checker for spt_translate: bus holds, pulses, fetch order and lock.
   Assumes a bind onto spt_translate, one clock sys_clk and active-high rst. */
`timescale 1ns/1ns
module spt_translate_checker (
    input wire sys_clk,
    input wire rst,
    input wire avWaitrequest,
    input wire [23:0] memAddr,
    input wire high_byte_enable_n,
    input wire memRead,
    input wire memWrite,
    input wire memLock,
    input wire [15:0] memWdata,
    input wire memReady,
    input wire exceptionRaise
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Local bus
    AST_RW_EXCL: assert property (!(memRead && memWrite))
        else $error("read and write requested together");
    AST_RD_HOLD: assert property (memRead && !memReady |=> memRead && $stable(memAddr))
        else $error("read request dropped or moved before ready");
    AST_WR_HOLD: assert property (memWrite && !memReady |=> memWrite && $stable(memWdata))
        else $error("write request dropped or changed before ready");
    // A faulting descriptor ends the fetch after its fourth word with no write-back, with the lock dropped and a fault raised.
    AST_FETCH_STEP: assert property (memLock && memRead && memReady |=>
        (memWrite && memLock) || (!memLock && exceptionRaise) ||
        (memRead && memAddr == $past(memAddr) + 24'h000002))
        else $error("descriptor word address did not step by two");
    AST_LOCK_END: assert property (memLock && memWrite && memReady |=> !memLock)
        else $error("lock not released after write-back");
    AST_WB_ACC: assert property (memLock && memWrite |-> memWdata[8])
        else $error("write-back without accessed bit");
    AST_HBE_LOCK: assert property (memLock |-> !high_byte_enable_n)
        else $error("descriptor word moved without high byte");
    AST_HBE_IDLE: assert property (!memRead && !memWrite |-> high_byte_enable_n)
        else $error("high byte enabled on an idle bus");
    // ==========================================
    // Software side and faults
    AST_WAIT_ONE: assert property ($fell(avWaitrequest) |=> avWaitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_EXC_ONE: assert property (exceptionRaise |=> !exceptionRaise)
        else $error("exception longer than one cycle");
    AST_EXC_NOWR: assert property (exceptionRaise |-> !memWrite)
        else $error("write cycle during a fault");
endmodule

//--- test/spt_mem_model.sv
/* Behavioural local-bus memory, 256 words, with a settable answer delay.
   Assumes the requester holds its request until it sees memReady. */
`timescale 1ns/1ns
module spt_mem_model (
    input wire sys_clk,
    input wire rst,
    input wire [23:0] memAddr,
    input wire memRead,
    input wire memWrite,
    input wire [15:0] memWdata,
    input wire [3:0] lat,
    output reg [15:0] memRdata,
    output reg memReady
);
    reg [15:0] mem [0:255];
    reg [3:0] waitCnt;
    // Data toggles outside the ready cycle so a late sample never looks valid.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            memReady <= 1'b0;
            waitCnt <= 4'h0;
            memRdata <= 16'hA5A5;
        end else if ((memRead || memWrite) && !memReady && waitCnt >= lat) begin
            memReady <= 1'b1;
            waitCnt <= 4'h0;
            memRdata <= mem[memAddr[8:1]];
            if (memWrite) begin
                mem[memAddr[8:1]] <= memWdata;
            end
        end else begin
            memReady <= 1'b0;
            memRdata <= ~memRdata;
            if ((memRead || memWrite) && !memReady) begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule

//--- test/segment_protect_translate_tb_top.sv
/* Self-checking bench: Avalon register access, descriptor loads and checks.
   Assumes spt_translate and spt_mem_model; descriptor table at byte 0x100. */
`timescale 1ns/1ns
`include "spt_regs.vh"
module segment_protect_translate_tb_top;
    logic sys_clk, rst, avRead, avWrite, avWaitrequest, high_byte_enable_n;
    logic memRead, memWrite, memLock, memReady, exceptionRaise, hbe;
    logic [7:0] avAddress;
    logic [31:0] avWritedata, avReaddata, q;
    logic [23:0] memAddr;
    logic [15:0] memWdata, memRdata;
    logic [3:0] lat, lastFlt = 4'h0;
    int n_mismatch = 0, samples_checked = 0, nExc = 0, nCyc = 0;
    localparam logic [1:0] RD = `SPT_KIND_READ, WR = `SPT_KIND_WRITE, EX = `SPT_KIND_EXEC;

    spt_translate uut (.sys_clk(sys_clk), .rst(rst), .avAddress(avAddress), .avRead(avRead),
        .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
        .avWaitrequest(avWaitrequest), .memAddr(memAddr), .high_byte_enable_n(high_byte_enable_n),
        .memRead(memRead), .memWrite(memWrite), .memLock(memLock), .memWdata(memWdata),
        .memRdata(memRdata), .memReady(memReady), .exceptionRaise(exceptionRaise));
    spt_mem_model mdl (.sys_clk(sys_clk), .rst(rst), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWdata(memWdata), .lat(lat), .memRdata(memRdata),
        .memReady(memReady));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Unlocked completed cycles are counted so a fault can be shown to suppress them.
    always @(posedge sys_clk) begin
        if (exceptionRaise === 1'b1) begin
            nExc++;
        end
        if (memReady && !memLock && (memRead || memWrite)) begin
            nCyc++;
            hbe = high_byte_enable_n;
        end
    end
    // ==========================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avAddress <= a;
        avWritedata <= d;
        avWrite <= wr;
        avRead <= !wr;
        @(posedge sys_clk);
        while (avWaitrequest !== 1'b0) begin
            n++;
            if (n > 500) begin
                n_mismatch++;
                stop_test();
            end
            @(posedge sys_clk);
        end
        q = avReaddata;
        avWrite <= 1'b0;
        avRead <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic fin(input logic [3:0] code, input int e0, input int c0);
        bus(1'b0, `SPT_OFF_STAT, 32'h0);
        // The code field keeps the last fault after the sticky bit is cleared.
        if (code != 4'h0) begin
            lastFlt = code;
        end
        chk(q[7:4], lastFlt, "fault code");
        chk(q[0], code != 4'h0, "sticky fault");
        chk(nExc - e0, code != 4'h0, "exception pulses");
        if (code != 4'h0) begin
            chk(nCyc, c0, "unlocked cycles");
        end
        bus(1'b1, `SPT_OFF_STAT, 32'h1);
    endtask
    task automatic ld(input logic [1:0] seg, input logic [15:0] sel, input logic [3:0] code);
        int e0, c0;
        e0 = nExc;
        c0 = nCyc;
        bus(1'b1, `SPT_OFF_SEL, {14'h0, seg, sel});
        fin(code, e0, c0);
    endtask
    task automatic acc(input logic [1:0] kind, input logic wide, input logic [1:0] seg,
            input logic [15:0] off, input logic [3:0] code, input logic [23:0] pa);
        int e0, c0;
        e0 = nExc;
        c0 = nCyc;
        bus(1'b1, `SPT_OFF_ACC, {10'h0, kind, wide, 1'b0, seg, off});
        fin(code, e0, c0);
        if (code == 4'h0) begin
            bus(1'b0, `SPT_OFF_ADDR, 32'h0);
            chk(q, {8'h0, pa}, "physical address");
        end
    endtask
    task automatic setd(input int n, input logic [7:0] ar, input logic [23:0] b,
            input logic [15:0] lim);
        mdl.mem[8'h80 + 4 * n] = lim;
        mdl.mem[8'h81 + 4 * n] = b[15:0];
        mdl.mem[8'h82 + 4 * n] = {ar, b[23:16]};
        mdl.mem[8'h83 + 4 * n] = 16'h0000;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_real();
        ld(2'h2, 16'h1234, 4'h0);
        acc(RD, 1'b0, 2'h2, 16'h0010, 4'h0, 24'h012350);
        chk(hbe, 1'b1, "byte enable even byte");
    endtask
    task automatic t_load();
        bus(1'b1, `SPT_OFF_CTRL, 32'h1);
        bus(1'b0, `SPT_OFF_CTRL, 32'h0);
        chk(q, 32'h00000001, "protection flag");
        bus(1'b1, `SPT_OFF_TBASE, 32'h100);
        acc(RD, 1'b0, 2'h3, 16'h0000, 4'h6, 24'h0);
        lat <= 4'h3;
        ld(2'h1, 16'h0008, 4'h0);
        lat <= 4'h0;
        chk(mdl.mem[8'h86], 16'h9300, "accessed write-back");
        bus(1'b0, `SPT_OFF_STAT, 32'h0);
        chk(q[9], 1'b1, "cache valid");
    endtask
    task automatic t_data();
        acc(RD, 1'b0, 2'h1, 16'h00FE, 4'h0, 24'h00027E);
        acc(RD, 1'b0, 2'h1, 16'h00FF, 4'h4, 24'h0);
        acc(RD, 1'b1, 2'h1, 16'h00FE, 4'h4, 24'h0);
        bus(1'b1, `SPT_OFF_DATA, 32'hABCD);
        acc(WR, 1'b1, 2'h1, 16'h0010, 4'h0, 24'h000190);
        chk(mdl.mem[8'hC8], 16'hABCD, "stored word");
        chk(hbe, 1'b0, "byte enable word");
        acc(RD, 1'b0, 2'h1, 16'h0011, 4'h0, 24'h000191);
        chk(hbe, 1'b0, "byte enable odd byte");
        bus(1'b0, `SPT_OFF_DATA, 32'h0);
        chk(q, 32'h000000AB, "odd byte data");
        acc(RD, 1'b1, 2'h1, 16'h0011, 4'h7, 24'h0);
        acc(EX, 1'b0, 2'h1, 16'h0000, 4'h2, 24'h0);
        ld(2'h2, 16'h0010, 4'h0);
        acc(WR, 1'b0, 2'h2, 16'h0004, 4'h5, 24'h0);
        acc(RD, 1'b0, 2'h2, 16'h0004, 4'h0, 24'h000204);
        ld(2'h2, 16'h0018, 4'h0);
        acc(RD, 1'b0, 2'h2, 16'h0FFF, 4'h4, 24'h0);
        acc(RD, 1'b0, 2'h2, 16'h1000, 4'h0, 24'h011000);
    endtask
    task automatic t_code();
        ld(2'h0, 16'h0020, 4'h0);
        acc(RD, 1'b0, 2'h0, 16'h0010, 4'h5, 24'h0);
        acc(WR, 1'b0, 2'h0, 16'h0010, 4'h5, 24'h0);
        acc(EX, 1'b0, 2'h0, 16'h0010, 4'h0, 24'h020010);
        ld(2'h0, 16'h0028, 4'h0);
        acc(EX, 1'b0, 2'h0, 16'h0000, 4'h3, 24'h0);
    endtask
    task automatic t_fault();
        ld(2'h3, 16'h0030, 4'h1);
        bus(1'b0, `SPT_OFF_STAT, 32'h0);
        chk(q[11], 1'b0, "cache after fault");
        acc(RD, 1'b0, 2'h3, 16'h0000, 4'h6, 24'h0);
        ld(2'h3, 16'h0038, 4'h2);
    endtask
    task automatic t_priv();
        bus(1'b1, `SPT_OFF_CTRL, 32'h3);
        acc(EX, 1'b0, 2'h0, 16'h0000, 4'h0, 24'h030000);
        acc(RD, 1'b0, 2'h1, 16'h0000, 4'h3, 24'h0);
    endtask

    initial begin
        rst = 1'b1;
        lat = 4'h0;
        avRead = 1'b0;
        avWrite = 1'b0;
        avAddress = 8'h00;
        avWritedata = 32'h0;
        setd(1, 8'h92, 24'h000180, 16'h00FE);
        setd(2, 8'h90, 24'h000200, 16'h00FF);
        setd(3, 8'h96, 24'h010000, 16'h0FFF);
        setd(4, 8'h98, 24'h020000, 16'h00FF);
        setd(5, 8'hBC, 24'h030000, 16'hFFFF);
        setd(6, 8'h12, 24'h040000, 16'h00FF);
        setd(7, 8'h82, 24'h050000, 16'h00FF);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_real();
        t_load();
        t_data();
        t_code();
        t_fault();
        t_priv();
        stop_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule

bind spt_translate spt_translate_checker u_chk (.sys_clk(sys_clk), .rst(rst),
    .avWaitrequest(avWaitrequest), .memAddr(memAddr), .high_byte_enable_n(high_byte_enable_n),
    .memRead(memRead), .memWrite(memWrite),
    .memLock(memLock), .memWdata(memWdata), .memReady(memReady),
    .exceptionRaise(exceptionRaise));
